// ===== remote_modem_model.sv
/*
 * remote serial equipment on the modem handshake lines.
 * assumes the bench raises its pause requests just after a clock edge.
 */
`timescale 1ns/1ps
module remote_modem_model
(
    // pause requests from the bench
    input wire logic i_pause_tx,
    input wire logic i_pause_dsr,
    // modem pins, active low
    output logic o_cts_n,
    output logic o_dsr_n
);
    // ********
    // pin drive
    // ********
    // high pauses sender
    assign o_cts_n = i_pause_tx;
    // a high ready line asks the device to stop sending
    assign o_dsr_n = i_pause_dsr;
endmodule

// ===== tb.sv
/*
 * self-checking bench for the baud generator and modem flow block.
 * assumes a zero-wait apb slave and the remote modem model on the pins.
 */
`timescale 1ns/1ps
module tb;
    // ********
    // signals
    // ********
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tx_idle = 1'b0, iso = 1'b0;
    logic pause_tx = 1'b0, pause_dsr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [7:0] level = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, r;
    logic pready, pslverr, e, cts_n, dsr_n, rts_n, dtr_n, hold, s_tick, b_tick;
    int n_mismatch = 0, total_checks = 0, cyc = 0, c;
    logic [7:0] codes [9] = '{8'h00, 8'h03, 8'h01, 8'h10, 8'h11, 8'h04, 8'h09, 8'h0F, 8'hF5};
    // design and far side
    uart_bgfc_top dut_u (.I_CLOCK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_RX_FIFO_LEVEL(level),
        .I_TX_IDLE(tx_idle), .I_ISO_MODE(iso), .I_CTS_N(cts_n), .I_DSR_N(dsr_n),
        .O_RTS_N(rts_n), .O_DTR_N(dtr_n), .O_TX_HOLD(hold), .O_SAMPLE_TICK(s_tick),
        .O_BIT_TICK(b_tick));
    remote_modem_model far_u (.i_pause_tx(pause_tx), .i_pause_dsr(pause_dsr),
        .o_cts_n(cts_n), .o_dsr_n(dsr_n));
    // clock and hang guard
    initial forever #2 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end
    // ********
    // tasks
    // ********
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(r, {24'h0, exp});
    endtask
    // cycles spanned by n ticks, after settling past a reload
    task automatic meas(input logic sel, input int n, input int exp);
        int k;
        k = 0;
        c = 0;
        repeat (3) do @(posedge clk); while ((sel ? b_tick : s_tick) !== 1'b1);
        while (k < n)
        begin
            @(posedge clk);
            c++;
            if ((sel ? b_tick : s_tick) === 1'b1) k++;
        end
        chk(c, exp);
    endtask
    // rts, dtr and hold after the pins have settled
    task automatic sees(input logic [2:0] exp);
        repeat (6) @(posedge clk);
        chk({29'h0, rts_n, dtr_n, hold}, {29'h0, exp});
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ********
    // tests
    // ********
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(uart_bgfc_pkg::IDX_PRESCALER, uart_bgfc_pkg::RST_PRESCALER);
        rd(uart_bgfc_pkg::IDX_SAMPLE_MULT, 8'h00);
        rd(6'h03, 8'h00);
        chk(e, 1'b1);
        meas(1'b1, 1, 16);
        $display("test reset values done");
        for (int i = 0; i < 9; i++)
        begin
            wr(uart_bgfc_pkg::IDX_SAMPLE_MULT, codes[i]);
            rd(uart_bgfc_pkg::IDX_SAMPLE_MULT, {4'h0, codes[i][3:0]});
            meas(1'b1, 1, codes[i][3:0] < 4 ? 16 : codes[i][3:0]);
        end
        wr(uart_bgfc_pkg::IDX_SAMPLE_MULT, 8'h04);
        meas(1'b1, 4, 16);
        wr(uart_bgfc_pkg::IDX_DIV_LOW, 8'h03);
        meas(1'b0, 2, 6);
        wr(uart_bgfc_pkg::IDX_DIV_HIGH, 8'h01);
        meas(1'b0, 1, 259);
        wr(uart_bgfc_pkg::IDX_DIV_HIGH, 8'h00);
        wr(uart_bgfc_pkg::IDX_DIV_LOW, 8'h00);
        c = 0;
        repeat (40) @(posedge clk);
        repeat (40)
        begin
            @(posedge clk);
            if (s_tick !== 1'b0) c++;
        end
        chk(c, 0);
        wr(uart_bgfc_pkg::IDX_DIV_LOW, 8'h03);
        iso <= 1'b1;
        meas(1'b1, 2, 6);
        iso <= 1'b0;
        wr(uart_bgfc_pkg::IDX_PRESCALER, 8'h0C);
        meas(1'b0, 2, 6);
        wr(uart_bgfc_pkg::IDX_MODEM_CTRL, 8'h80);
        rd(uart_bgfc_pkg::IDX_MODEM_CTRL, 8'h00);
        wr(uart_bgfc_pkg::IDX_ENH_FEAT, 8'h10);
        wr(uart_bgfc_pkg::IDX_MODEM_CTRL, 8'h80);
        rd(uart_bgfc_pkg::IDX_MODEM_CTRL, 8'h80);
        meas(1'b1, 2, 36);
        $display("test baud generator done");
        wr(uart_bgfc_pkg::IDX_ENH_FEAT, 8'h00);
        wr(uart_bgfc_pkg::IDX_MODEM_CTRL, 8'h23);
        level <= 8'h60;
        sees(3'b100);
        level <= 8'h40;
        sees(3'b100);
        level <= 8'h1F;
        sees(3'b000);
        wr(uart_bgfc_pkg::IDX_MODEM_CTRL, 8'h21);
        sees(3'b100);
        wr(uart_bgfc_pkg::IDX_MODEM_CTRL, 8'h23);
        pause_tx <= 1'b1;
        sees(3'b000);
        tx_idle <= 1'b1;
        sees(3'b001);
        pause_tx <= 1'b0;
        sees(3'b000);
        $display("test legacy flow done");
        wr(uart_bgfc_pkg::IDX_ENH_FEAT, 8'h50);
        pause_tx <= 1'b1;
        level <= 8'h60;
        sees(3'b100);
        wr(uart_bgfc_pkg::IDX_ENH_FEAT, 8'h90);
        sees(3'b001);
        pause_tx <= 1'b0;
        level <= 8'h00;
        wr(uart_bgfc_pkg::IDX_ENH_FEAT, 8'h00);
        wr(uart_bgfc_pkg::IDX_MODEM_CTRL, 8'h01);
        wr(uart_bgfc_pkg::IDX_ADD_CTRL, 8'h0C);
        sees(3'b100);
        level <= 8'h60;
        sees(3'b110);
        level <= 8'h1F;
        sees(3'b100);
        pause_dsr <= 1'b1;
        sees(3'b101);
        wr(uart_bgfc_pkg::IDX_ADD_CTRL, 8'h10);
        sees(3'b110);
        tx_idle <= 1'b0;
        sees(3'b100);
        wr(uart_bgfc_pkg::IDX_ADD_CTRL, 8'h18);
        sees(3'b110);
        $display("test enhanced and dtr flow done");
        wrap_up();
    end
endmodule

// ===== uart_baud_div.sv
/*
 * divisor and sample-multiple counters driven by the prescaler tick.
 * assumes divisor zero means stopped and the cycles per bit are 4 to 16.
 */
`timescale 1ns/1ps
module uart_baud_div
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // control
    input wire logic i_reload,
    input wire logic i_pre_tick,
    input wire logic i_iso,
    input wire logic [15:0] i_divisor,
    input wire logic [4:0] i_cycles_per_bit,
    // ticks out
    output logic o_sample_tick,
    output logic o_bit_tick
);
    logic [15:0] div_cnt_q;
    logic [4:0] smp_cnt_q;
    wire div_end = i_pre_tick && (i_divisor != 16'h0000)
                   && (div_cnt_q == i_divisor - 16'h0001);
    wire smp_end = i_iso || (smp_cnt_q == i_cycles_per_bit - 5'h01);

    // divide the prescaler tick by the divisor, then by the sample count
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            div_cnt_q <= 16'h0000;
            smp_cnt_q <= 5'h00;
            o_sample_tick <= 1'b0;
            o_bit_tick <= 1'b0;
        end
        else if (i_reload)
        begin
            div_cnt_q <= 16'h0000;
            smp_cnt_q <= 5'h00;
            o_sample_tick <= 1'b0;
            o_bit_tick <= 1'b0;
        end
        else
        begin
            o_sample_tick <= div_end;
            o_bit_tick <= div_end && smp_end;
            if (div_end)
            begin
                div_cnt_q <= 16'h0000;
                smp_cnt_q <= smp_end ? 5'h00 : smp_cnt_q + 5'h01;
            end
            else if (i_pre_tick)
            begin
                div_cnt_q <= div_cnt_q + 16'h0001;
            end
        end
    end

    // bit tick on a sample tick
    bit_on_sample_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_bit_tick |-> o_sample_tick)
        else $error("bit tick without sample tick");
    div_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_divisor == 16'h0000) |=> !o_sample_tick)
        else $error("sample tick with divisor zero");
endmodule

// ===== uart_bgfc_pkg.sv
/*
 * constants shared by the baud generator and the modem flow control block:
 * register indices, field positions, reset values and timing figures.
 * assumes a single 250 MHz reference clock and 32-bit APB registers.
 */
package uart_bgfc_pkg;
    // ***********************************************************
    // register indices; byte address is four times the index
    // ***********************************************************
    localparam logic [5:0] IDX_ADD_CTRL = 6'h00;
    localparam logic [5:0] IDX_PRESCALER = 6'h01;
    localparam logic [5:0] IDX_SAMPLE_MULT = 6'h02;
    localparam logic [5:0] IDX_MODEM_CTRL = 6'h04;
    localparam logic [5:0] IDX_ENH_FEAT = 6'h05;
    localparam logic [5:0] IDX_DIV_LOW = 6'h06;
    localparam logic [5:0] IDX_DIV_HIGH = 6'h07;
    localparam logic [5:0] IDX_FLOW_LOW = 6'h08;
    localparam logic [5:0] IDX_FLOW_HIGH = 6'h09;
    localparam logic [5:0] IDX_STATUS = 6'h0A;
    // ***********************************************************
    // field positions
    // ***********************************************************
    localparam int MODEM_DTR_BIT = 0;
    localparam int MODEM_RTS_BIT = 1;
    localparam int MODEM_AUTO_FLOW_BIT = 5;
    localparam int MODEM_PRESCALE_BIT = 7;
    localparam int FEAT_ENHANCED_BIT = 4;
    localparam int FEAT_AUTO_RTS_BIT = 6;
    localparam int FEAT_AUTO_CTS_BIT = 7;
    localparam int ADD_AUTO_DSR_BIT = 2;
    localparam int ADD_DTR_CFG_LO = 3;
    localparam int ADD_DTR_CFG_HI = 4;
    // ***********************************************************
    // reset values and timing
    // ***********************************************************
    localparam logic [7:0] RST_PRESCALER = 8'h08;
    localparam logic [3:0] RST_SAMPLE_MULT = 4'h0;
    localparam logic [7:0] RST_DIV_LOW = 8'h01;
    localparam logic [7:0] RST_FLOW_LOW = 8'h20;
    localparam logic [7:0] RST_FLOW_HIGH = 8'h60;
    localparam logic [7:0] PRESCALE_ONE = 8'h08;
    localparam logic [3:0] SAMPLE_MIN_CODE = 4'h4;
    localparam logic [4:0] SAMPLE_DEFAULT = 5'h10;
    localparam int CLOCK_PERIOD_NS = 4;
endpackage

// ===== uart_bgfc_top.sv
/*
 * baud rate generator and automatic out-of-band flow control of one serial
 * channel, with its control registers on an APB slave.
 * assumes the transmitter checks O_TX_HOLD only between characters and
 * reports I_TX_IDLE on this clock; CTS and DSR arrive as raw pins.
 */
`timescale 1ns/1ps
module uart_bgfc_top
(
    // clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RST,
    // apb slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // channel status from fifo and transmitter
    input wire logic [7:0] I_RX_FIFO_LEVEL,
    input wire logic I_TX_IDLE,
    input wire logic I_ISO_MODE,
    // modem pins, active low
    input wire logic I_CTS_N,
    input wire logic I_DSR_N,
    output logic O_RTS_N,
    output logic O_DTR_N,
    // to transmitter and receiver
    output logic O_TX_HOLD,
    output logic O_SAMPLE_TICK,
    output logic O_BIT_TICK
);
    // ***********************************************************
    // declarations
    // ***********************************************************
    logic [1:0] pin_meta_q;
    logic [1:0] pin_sync_q;
    logic [7:0] add_ctrl_q;
    logic [7:0] prescaler_q;
    logic [3:0] sample_mult_q;
    logic [7:0] modem_ctrl_q;
    logic [7:0] enh_feat_q;
    logic [7:0] div_low_q;
    logic [7:0] divisor_high_byte_q;
    logic [7:0] flow_low_q;
    logic [7:0] flow_high_q;
    logic rts_block_q;
    logic dtr_block_q;
    logic reload_q;
    logic pre_tick;
    logic sample_tick;
    logic bit_tick;

    // ***********************************************************
    // pin synchronisers
    // ***********************************************************
    // two flops per pin; bit 0 is CTS, bit 1 is DSR
    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            pin_meta_q <= 2'h3;
            pin_sync_q <= 2'h3;
        end
        else
        begin
            pin_meta_q <= {I_DSR_N, I_CTS_N};
            pin_sync_q <= pin_meta_q;
        end
    end

    // ***********************************************************
    // apb decode
    // ***********************************************************
    // setup phase captures read data, access phase commits writes
    wire [5:0] idx = I_PADDR[7:2];
    wire setup = I_PSEL && !I_PENABLE;
    wire wr = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY && !O_PSLVERR;
    wire hit = (I_PADDR[1:0] == 2'h0) && (idx <= uart_bgfc_pkg::IDX_STATUS)
               && (idx != 6'h03);
    wire enhanced = enh_feat_q[uart_bgfc_pkg::FEAT_ENHANCED_BIT];
    wire [7:0] wbyte = I_PWDATA[7:0];
    wire wr_add = wr && (idx == uart_bgfc_pkg::IDX_ADD_CTRL);
    wire wr_pre = wr && (idx == uart_bgfc_pkg::IDX_PRESCALER);
    wire wr_smp = wr && (idx == uart_bgfc_pkg::IDX_SAMPLE_MULT);
    wire wr_modem = wr && (idx == uart_bgfc_pkg::IDX_MODEM_CTRL);
    wire wr_feat = wr && (idx == uart_bgfc_pkg::IDX_ENH_FEAT);
    wire wr_div_lo = wr && (idx == uart_bgfc_pkg::IDX_DIV_LOW);
    wire wr_div_hi = wr && (idx == uart_bgfc_pkg::IDX_DIV_HIGH);
    wire wr_flow_lo = wr && (idx == uart_bgfc_pkg::IDX_FLOW_LOW);
    wire wr_flow_hi = wr && (idx == uart_bgfc_pkg::IDX_FLOW_HIGH);
    wire [7:0] modem_ctrl_d = enhanced ? wbyte
                     : {modem_ctrl_q[uart_bgfc_pkg::MODEM_PRESCALE_BIT], wbyte[6:0]};
    wire [7:0] status = {3'h0, O_TX_HOLD, pin_sync_q, dtr_block_q, rts_block_q};
    wire [7:0] rd_mux =
        (idx == uart_bgfc_pkg::IDX_ADD_CTRL) ? add_ctrl_q :
        (idx == uart_bgfc_pkg::IDX_PRESCALER) ? prescaler_q :
        (idx == uart_bgfc_pkg::IDX_SAMPLE_MULT) ? {4'h0, sample_mult_q} :
        (idx == uart_bgfc_pkg::IDX_MODEM_CTRL) ? modem_ctrl_q :
        (idx == uart_bgfc_pkg::IDX_ENH_FEAT) ? enh_feat_q :
        (idx == uart_bgfc_pkg::IDX_DIV_LOW) ? div_low_q :
        (idx == uart_bgfc_pkg::IDX_DIV_HIGH) ? divisor_high_byte_q :
        (idx == uart_bgfc_pkg::IDX_FLOW_LOW) ? flow_low_q :
        (idx == uart_bgfc_pkg::IDX_FLOW_HIGH) ? flow_high_q :
        (idx == uart_bgfc_pkg::IDX_STATUS) ? status : 8'h00;

    // bus answer: ready every cycle, error and data settled at setup
    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            O_PRDATA <= 32'h00000000;
            O_PREADY <= 1'b1;
            O_PSLVERR <= 1'b0;
        end
        else if (setup)
        begin
            O_PRDATA <= (hit && !I_PWRITE) ? {24'h000000, rd_mux} : 32'h00000000;
            O_PSLVERR <= !hit;
        end
    end

    // ***********************************************************
    // control registers
    // ***********************************************************
    // sample multiple resets to zero
    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            add_ctrl_q <= 8'h00;
            prescaler_q <= uart_bgfc_pkg::RST_PRESCALER;
            sample_mult_q <= uart_bgfc_pkg::RST_SAMPLE_MULT;
            modem_ctrl_q <= 8'h00;
            enh_feat_q <= 8'h00;
            div_low_q <= uart_bgfc_pkg::RST_DIV_LOW;
            divisor_high_byte_q <= 8'h00;
            flow_low_q <= uart_bgfc_pkg::RST_FLOW_LOW;
            flow_high_q <= uart_bgfc_pkg::RST_FLOW_HIGH;
        end
        else
        begin
            if (wr_add) add_ctrl_q <= wbyte;
            if (wr_pre) prescaler_q <= wbyte;
            if (wr_smp) sample_mult_q <= wbyte[3:0];
            if (wr_modem) modem_ctrl_q <= modem_ctrl_d;
            if (wr_feat) enh_feat_q <= wbyte;
            if (wr_div_lo) div_low_q <= wbyte;
            if (wr_div_hi) divisor_high_byte_q <= wbyte;
            if (wr_flow_lo) flow_low_q <= wbyte;
            if (wr_flow_hi) flow_high_q <= wbyte;
        end
    end

    // ***********************************************************
    // baud rate generator
    // ***********************************************************
    // divisor from two bytes
    wire [15:0] divisor = {divisor_high_byte_q, div_low_q};
    wire [7:0] pre_div = modem_ctrl_q[uart_bgfc_pkg::MODEM_PRESCALE_BIT]
                         ? prescaler_q : uart_bgfc_pkg::PRESCALE_ONE;
    wire [4:0] sample_cycles_per_bit = (sample_mult_q < uart_bgfc_pkg::SAMPLE_MIN_CODE)
                                       ? uart_bgfc_pkg::SAMPLE_DEFAULT : {1'b0, sample_mult_q};

    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
            reload_q <= 1'b0;
        else
            reload_q <= wr_pre || wr_smp || wr_div_lo || wr_div_hi || wr_modem;
    end

    uart_prescale_tick u_prescale
    (
        .i_clk(I_CLOCK),
        .i_rst(I_RST),
        .i_reload(reload_q),
        .i_div(pre_div),
        .o_tick(pre_tick)
    );

    uart_baud_div u_div
    (
        .i_clk(I_CLOCK),
        .i_rst(I_RST),
        .i_reload(reload_q),
        .i_pre_tick(pre_tick),
        .i_iso(I_ISO_MODE),
        .i_divisor(divisor),
        .i_cycles_per_bit(sample_cycles_per_bit),
        .o_sample_tick(sample_tick),
        .o_bit_tick(bit_tick)
    );

    // ***********************************************************
    // out-of-band flow control
    // ***********************************************************
    // legacy joint enable, or separate RTS and CTS bits in enhanced mode
    wire auto_rts = enhanced ? enh_feat_q[uart_bgfc_pkg::FEAT_AUTO_RTS_BIT]
                             : modem_ctrl_q[uart_bgfc_pkg::MODEM_AUTO_FLOW_BIT];
    wire auto_cts = enhanced ? enh_feat_q[uart_bgfc_pkg::FEAT_AUTO_CTS_BIT]
                             : modem_ctrl_q[uart_bgfc_pkg::MODEM_AUTO_FLOW_BIT];
    wire [1:0] dtr_cfg = add_ctrl_q[uart_bgfc_pkg::ADD_DTR_CFG_HI:uart_bgfc_pkg::ADD_DTR_CFG_LO];
    wire lvl_high = I_RX_FIFO_LEVEL >= flow_high_q;
    wire lvl_low = I_RX_FIFO_LEVEL < flow_low_q;
    wire tx_stop = (auto_cts && pin_sync_q[0])
                   || (add_ctrl_q[uart_bgfc_pkg::ADD_AUTO_DSR_BIT] && pin_sync_q[1]);
    wire rts_n_d = !(modem_ctrl_q[uart_bgfc_pkg::MODEM_RTS_BIT] && !(auto_rts && rts_block_q));
    wire dtr_on = modem_ctrl_q[uart_bgfc_pkg::MODEM_DTR_BIT];
    wire dtr_n_d = (dtr_cfg == 2'h1) ? !(dtr_on && !dtr_block_q) :
                   (dtr_cfg == 2'h2) ? I_TX_IDLE :
                   (dtr_cfg == 2'h3) ? !I_TX_IDLE : !dtr_on;

    // level hysteresis, transmit hold and registered pins
    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            rts_block_q <= 1'b0;
            dtr_block_q <= 1'b0;
            O_TX_HOLD <= 1'b0;
            O_RTS_N <= 1'b1;
            O_DTR_N <= 1'b1;
            O_SAMPLE_TICK <= 1'b0;
            O_BIT_TICK <= 1'b0;
        end
        else
        begin
            if (lvl_high) rts_block_q <= 1'b1;
            else if (lvl_low) rts_block_q <= 1'b0;
            if (lvl_high) dtr_block_q <= 1'b1;
            else if (lvl_low) dtr_block_q <= 1'b0;
            if (!tx_stop) O_TX_HOLD <= 1'b0;
            else if (I_TX_IDLE) O_TX_HOLD <= 1'b1;
            O_RTS_N <= rts_n_d;
            O_DTR_N <= dtr_n_d;
            O_SAMPLE_TICK <= sample_tick;
            O_BIT_TICK <= bit_tick;
        end
    end

    // ***********************************************************
    // checks
    // ***********************************************************
    // software bit forces RTS off
    rts_override_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        !modem_ctrl_q[uart_bgfc_pkg::MODEM_RTS_BIT] |=> O_RTS_N)
        else $error("RTS active with software bit clear");
    rts_upper_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        (lvl_high && auto_rts) ##1 auto_rts |=> O_RTS_N)
        else $error("RTS still active at upper level");
    rts_release_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        (lvl_low && !lvl_high) ##1 modem_ctrl_q[uart_bgfc_pkg::MODEM_RTS_BIT] |=> !O_RTS_N)
        else $error("RTS not restored below lower level");
    dtr_upper_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        (lvl_high && dtr_cfg == 2'h1) ##1 (dtr_cfg == 2'h1) |=> O_DTR_N)
        else $error("DTR still active at upper level");
    dtr_release_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        (lvl_low && !lvl_high) ##1 (dtr_cfg == 2'h1 && dtr_on) |=> !O_DTR_N)
        else $error("DTR not restored below lower level");
    hold_idle_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        $rose(O_TX_HOLD) |-> $past(I_TX_IDLE))
        else $error("hold raised during a character");
    tx_resume_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        !tx_stop |=> !O_TX_HOLD)
        else $error("hold kept without stop condition");
    dsr_hold_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        (add_ctrl_q[uart_bgfc_pkg::ADD_AUTO_DSR_BIT] && pin_sync_q[1] && I_TX_IDLE)
        |=> O_TX_HOLD)
        else $error("DSR stop ignored while idle");
    prescale_lock_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        (wr_modem && !enhanced) |=> $stable(modem_ctrl_q[uart_bgfc_pkg::MODEM_PRESCALE_BIT]))
        else $error("prescale enable changed outside enhanced mode");
    sample_read_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        (setup && idx == uart_bgfc_pkg::IDX_SAMPLE_MULT) |=> (O_PRDATA[7:4] == 4'h0))
        else $error("sample multiple upper bits not zero");
    sc_decode_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        (sample_mult_q <= 4'h3) |-> (sample_cycles_per_bit == 5'h10))
        else $error("low code not decoded as sixteen");
    slverr_map_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        (setup && !hit) |=> O_PSLVERR)
        else $error("unmapped index not refused");
    reload_quiet_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        reload_q |-> ##2 !(O_SAMPLE_TICK || O_BIT_TICK))
        else $error("tick right after a counter reload");
endmodule

// ===== uart_prescale_tick.sv
/*
 * fractional prescaler: one tick on average every div/8 clock cycles.
 * assumes div is the raw prescaler byte, M in bits 7:3 and N in bits 2:0.
 */
`timescale 1ns/1ps
module uart_prescale_tick
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // control
    input wire logic i_reload,
    input wire logic [7:0] i_div,
    // tick out
    output logic o_tick
);
    logic [8:0] acc_q;
    wire [7:0] div_eff = (i_div < uart_bgfc_pkg::PRESCALE_ONE) ? uart_bgfc_pkg::PRESCALE_ONE
                                                               : i_div;
    wire [8:0] sum = acc_q + 9'h008;
    wire hit = sum >= {1'b0, div_eff};

    // eighths accumulator, subtracts the divide value on each tick
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            acc_q <= 9'h000;
            o_tick <= 1'b0;
        end
        else if (i_reload)
        begin
            acc_q <= 9'h000;
            o_tick <= 1'b0;
        end
        else
        begin
            acc_q <= hit ? sum - {1'b0, div_eff} : sum;
            o_tick <= hit;
        end
    end

    bypass_tick_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (div_eff == uart_bgfc_pkg::PRESCALE_ONE && !i_reload) |=> o_tick)
        else $error("prescaler of one missed a tick");
endmodule
